/* verilog/fsru_status_unit.sv */
/*
  Status register unit of a serial flash: decodes read-status and
  write-status opcodes from the SPI pins, shifts both status bytes out,
  and keeps the lock, protect, error, latch and reset-enable bits.
  Assumes SPI pins are asynchronous and the serial clock runs well below
  a quarter of mclk_i; engines drive eng_i synchronously to mclk_i.
*/
// Overview of operation
// [R1] Opcode 05h starts status bits on output
// [R2] Two bytes MSB first, wrapping after byte two
// [R3] Every pass reloads live status values
// [R4] Status read accepted even while busy
// [R5] Chip select release ends read, floats output
// [R6] Byte one layout; bits six, three zero
// [R7] Write-status changes only bits seven, two
// [R8] Lock plus asserted pin freezes protect
// [R9] Unlocked protect changes freely; lock resets zero
// [R10] Asserted pin: lock only rises
// [R11] Error flag refreshed after every operation
// [R12] Aborted operations never set error flag
// [R13] Mirror bit shows protect pin level
// [R14] Protect bit refuses all array writes
// [R15] Cleared latch rejects writing commands
// [R16] Latch zero after power-up and reset
// [R17] Latch clears on listed completions, aborts
// [R18] Partial opcode aborts keep latch set
// [R19] Busy flag tracks internal operation
// [R20] Opcode 01h plus byte, applied at release
// [R21] Byte two: reset enable, busy copy
// [R22] Host sets latch before write-status
// [R23] Sample on rising, drive on falling
// [R24] Truncated write-status changes nothing, clears latch
`timescale 1ns/1ps
module fsru_status_unit
  import fsru_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic si_i,
  input wire logic wp_n_i,
  input wire fsru_engine_in_t eng_i,
  output logic so_o,
  output logic so_oe_o,
  output fsru_status_t status_o,
  output logic reset_taken_o
);

  logic [3:0] pins_sync;
  logic cs_n_s;
  logic sck_s;
  logic si_s;
  logic wp_n_s;
  logic sck_prev_reg;
  logic cs_n_prev_reg;
  logic sck_rise;
  logic sck_fall;
  logic cs_release;
  logic active;

  fsru_state_t state_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] shift_in_reg;
  logic [7:0] opcode_next;
  logic [3:0] status_idx_reg;
  logic [15:0] status_shift_reg;
  logic [15:0] status_live;
  logic wsr_full_reg;
  logic [7:0] wsr_data_reg;

  logic lock_reg;
  logic prot_reg;
  logic latch_reg;
  logic err_reg;
  logic reset_command_enable_reg;
  logic mirror_reg;

  logic wsr_release;
  logic wsr_apply;
  logic chk_accept;
  logic chk_lock;
  logic chk_prot;
  logic reset_take;

  // Pins cross into mclk_i before any decoding
  fsru_sync #(
    .WIDTH(4),
    .RESET_VAL(FSRU_PIN_RST)
  ) u_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .async_i({cs_n_i, sck_i, si_i, wp_n_i}),
    .sync_o(pins_sync)
  );

  assign cs_n_s = pins_sync[3];
  assign sck_s = pins_sync[2];
  assign si_s = pins_sync[1];
  assign wp_n_s = pins_sync[0];

  // Edge history of synchronised pins
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sck_prev_reg <= FSRU_PIN_RST[2];
      cs_n_prev_reg <= FSRU_PIN_RST[3];
    end else begin
      sck_prev_reg <= sck_s;
      cs_n_prev_reg <= cs_n_s;
    end
  end

  // Serial clock edges only count inside a frame
  assign active = !cs_n_s;
  assign sck_rise = active && sck_s && !sck_prev_reg; // R23
  assign sck_fall = active && !sck_s && sck_prev_reg; // R23
  assign cs_release = cs_n_s && !cs_n_prev_reg;
  assign opcode_next = {shift_in_reg[6:0], si_s};

  // Frame sequencer: opcode bits, then read, write-status or skip
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= FSRU_ST_OPCODE;
      bit_cnt_reg <= FSRU_FIRST_BYTE_BIT;
      shift_in_reg <= 8'h00;
    end else if (!active) begin
      state_reg <= FSRU_ST_OPCODE; // R5
      bit_cnt_reg <= FSRU_FIRST_BYTE_BIT;
    end else if (sck_rise) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      shift_in_reg <= opcode_next;
      if (state_reg == FSRU_ST_OPCODE && bit_cnt_reg == FSRU_LAST_BYTE_BIT) begin
        // Decoded regardless of busy, so polling works during operations
        case (opcode_next)
          FSRU_OPC_READ_STATUS: begin
            state_reg <= FSRU_ST_READ; // R1 R4
          end
          FSRU_OPC_WRITE_STATUS: begin
            state_reg <= FSRU_ST_WSR; // R20
          end
          default: begin
            state_reg <= FSRU_ST_SKIP;
          end
        endcase
      end
    end
  end

  // Write-status data byte; extra bytes ignored, framing still tracked
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wsr_full_reg <= 1'b0;
      wsr_data_reg <= 8'h00;
    end else if (!active) begin
      wsr_full_reg <= 1'b0;
    end else if (sck_rise && state_reg == FSRU_ST_WSR && !wsr_full_reg &&
                 bit_cnt_reg == FSRU_LAST_BYTE_BIT) begin
      wsr_full_reg <= 1'b1;
      wsr_data_reg <= opcode_next;
    end
  end

  // Live status image; busy is not registered so polls see it at once
  assign status_o.protection_lock = lock_reg;
  assign status_o.program_error_flag = err_reg;
  assign status_o.protect_pin_mirror = mirror_reg;
  assign status_o.array_protect = prot_reg; // R14
  assign status_o.write_latch = latch_reg; // R15
  assign status_o.busy_flag = eng_i.busy; // R19
  assign status_o.reset_command_enable = reset_command_enable_reg;
  assign status_live = fsru_pack_status(status_o); // R6 R21

  // Output shifter: reload at index zero so each pass is fresh
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      status_idx_reg <= FSRU_FIRST_STATUS_IDX;
      status_shift_reg <= 16'h0000;
      so_o <= 1'b0;
    end else if (state_reg != FSRU_ST_READ) begin
      status_idx_reg <= FSRU_FIRST_STATUS_IDX;
    end else if (sck_fall) begin
      status_idx_reg <= status_idx_reg + 4'h1; // R2
      if (status_idx_reg == FSRU_FIRST_STATUS_IDX) begin
        so_o <= status_live[FSRU_STATUS_BITS-1]; // R3
        status_shift_reg <= {status_live[14:0], 1'b0};
      end else begin
        so_o <= status_shift_reg[FSRU_STATUS_BITS-1]; // R2
        status_shift_reg <= {status_shift_reg[14:0], 1'b0};
      end
    end
  end

  // Driver enabled only in a read frame; release floats it
  assign so_oe_o = (state_reg == FSRU_ST_READ); // R5

  // Write-status closes at chip select release
  assign wsr_release = cs_release && state_reg == FSRU_ST_WSR;
  assign wsr_apply = wsr_release && latch_reg && wsr_full_reg &&
                     bit_cnt_reg == FSRU_FIRST_BYTE_BIT && chk_accept; // R15 R24

  fsru_wsr_check u_wsr_check (
    .lock_i(lock_reg),
    .prot_i(prot_reg),
    .wp_asserted_i(!wp_n_s),
    .data_i(wsr_data_reg),
    .accept_o(chk_accept),
    .lock_next_o(chk_lock),
    .prot_next_o(chk_prot)
  );

  // Only lock and protect are writable by write-status
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      lock_reg <= FSRU_RST_LOCK; // R9
      prot_reg <= FSRU_RST_PROT;
    end else if (wsr_apply) begin
      lock_reg <= chk_lock; // R7 R10
      prot_reg <= chk_prot; // R7 R8
    end
  end

  // Pin mirror: one while the protect pin is released
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      mirror_reg <= 1'b1;
    end else begin
      mirror_reg <= wp_n_s; // R13
    end
  end

  // Error flag rewritten by each finished operation; aborts never report done
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      err_reg <= FSRU_RST_ERR;
    end else if (eng_i.op_done) begin
      err_reg <= eng_i.op_fail; // R11 R12
    end
  end

  // Reset operation only honoured with reset command enabled
  assign reset_take = eng_i.reset_op && reset_command_enable_reg;
  assign reset_taken_o = reset_take;

  // Reset command enable survives reset operations
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      reset_command_enable_reg <= FSRU_RST_RESET_COMMAND_ENABLE; // R21
    end else if (eng_i.reset_command_enable_wr) begin
      reset_command_enable_reg <= eng_i.reset_command_enable_val;
    end
  end

  // Write latch; a set in the clear cycle wins so no enable is lost
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      latch_reg <= FSRU_RST_LATCH; // R16
    end else if (eng_i.wel_set) begin
      latch_reg <= 1'b1; // R22
    end else if (wsr_release || eng_i.wel_clr || eng_i.hold_abort || reset_take) begin
      // Skip-state frames never clear: partial or unknown opcodes keep it
      latch_reg <= 1'b0; // R16 R17 R18 R24
    end
  end

  // Assertions
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_read_opcode;
    sck_rise && state_reg == FSRU_ST_OPCODE && bit_cnt_reg == FSRU_LAST_BYTE_BIT &&
      opcode_next == FSRU_OPC_READ_STATUS;
  endsequence

  sequence s_wsr_bad_end;
    wsr_release && (!wsr_full_reg || bit_cnt_reg != FSRU_FIRST_BYTE_BIT);
  endsequence

  property p_read_start;
    s_read_opcode |=> so_oe_o && state_reg == FSRU_ST_READ;
  endproperty
  a_read_start: assert property (p_read_start) else $error("read opcode not decoded"); // R1

  property p_wrap;
    (sck_fall && state_reg == FSRU_ST_READ && status_idx_reg == FSRU_LAST_STATUS_IDX)
      |=> status_idx_reg == FSRU_FIRST_STATUS_IDX;
  endproperty
  a_wrap: assert property (p_wrap) else $error("status index did not wrap"); // R2

  property p_fresh;
    (sck_fall && state_reg == FSRU_ST_READ && status_idx_reg == FSRU_FIRST_STATUS_IDX)
      |=> so_o == $past(status_live[FSRU_STATUS_BITS-1]);
  endproperty
  a_fresh: assert property (p_fresh) else $error("pass not reloaded"); // R3

  property p_release_float;
    cs_n_s |=> !so_oe_o;
  endproperty
  a_release_float: assert property (p_release_float) else $error("output driven outside frame"); // R5

  property p_reserved;
    !status_live[8 + FSRU_B1_RSVD6] && !status_live[8 + FSRU_B1_RSVD3] &&
      status_live[8 + FSRU_B1_BUSY] == eng_i.busy && status_live[FSRU_B2_BUSY] == eng_i.busy;
  endproperty
  a_reserved: assert property (p_reserved) else $error("status layout wrong"); // R6

  property p_prot_frozen;
    (lock_reg && !wp_n_s) |=> $stable(prot_reg);
  endproperty
  a_prot_frozen: assert property (p_prot_frozen) else $error("protect changed while locked"); // R8

  property p_lock_no_fall;
    !wp_n_s |=> !$fell(lock_reg);
  endproperty
  a_lock_no_fall: assert property (p_lock_no_fall) else $error("lock cleared with pin asserted"); // R10

  property p_err_refresh;
    eng_i.op_done |=> err_reg == $past(eng_i.op_fail);
  endproperty
  a_err_refresh: assert property (p_err_refresh) else $error("error flag not refreshed"); // R11

  property p_err_hold;
    !eng_i.op_done |=> $stable(err_reg);
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error flag moved without operation"); // R12

  property p_mirror;
    mirror_reg == $past(wp_n_s);
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror does not follow pin"); // R13

  property p_wsr_bad;
    s_wsr_bad_end ##0 !eng_i.wel_set |=> !latch_reg && $stable(lock_reg) && $stable(prot_reg);
  endproperty
  a_wsr_bad: assert property (p_wsr_bad) else $error("truncated write-status had effect"); // R24

  property p_reset_latch;
    (reset_take && !eng_i.wel_set) |=> !latch_reg;
  endproperty
  a_reset_latch: assert property (p_reset_latch) else $error("latch survived reset operation"); // R16

  // Any closed write-status frame drops the latch unless a new enable arrives
  property p_wsr_clears_latch;
    (wsr_release && !eng_i.wel_set) |=> !latch_reg;
  endproperty
  a_wsr_clears_latch: assert property (p_wsr_clears_latch) else $error("latch kept after write-status"); // R20

  // Enable pulse always lands, even against a clear
  property p_latch_set;
    eng_i.wel_set |=> latch_reg;
  endproperty
  a_latch_set: assert property (p_latch_set) else $error("write enable lost"); // R22

  // Partial or unknown opcode frames leave a set latch alone
  property p_latch_keep;
    (cs_release && state_reg != FSRU_ST_WSR && latch_reg && !eng_i.wel_clr && !eng_i.hold_abort && !reset_take)
      |=> latch_reg;
  endproperty
  a_latch_keep: assert property (p_latch_keep) else $error("latch cleared by aborted opcode"); // R18

endmodule : fsru_status_unit

/* verilog/fsru_pkg.sv */
/*
  Shared constants, state codes and carrier structs of the flash status
  register unit: opcodes, status bit positions, reset values and the
  signal bundles exchanged with the program, erase and OTP engines.
  Assumes nothing of its surroundings beyond a SystemVerilog compiler.
*/
package fsru_pkg;

  // Command opcodes decoded by this block
  localparam logic [7:0] FSRU_OPC_READ_STATUS = 8'h05;
  localparam logic [7:0] FSRU_OPC_WRITE_STATUS = 8'h01;

  // Serial framing
  localparam int FSRU_STATUS_BITS = 16;
  localparam logic [3:0] FSRU_LAST_STATUS_IDX = 4'hF;
  localparam logic [3:0] FSRU_FIRST_STATUS_IDX = 4'h0;
  localparam logic [2:0] FSRU_LAST_BYTE_BIT = 3'h7;
  localparam logic [2:0] FSRU_FIRST_BYTE_BIT = 3'h0;

  // Status byte one positions
  localparam int FSRU_B1_LOCK = 7;
  localparam int FSRU_B1_RSVD6 = 6;
  localparam int FSRU_B1_ERR = 5;
  localparam int FSRU_B1_MIRROR = 4;
  localparam int FSRU_B1_RSVD3 = 3;
  localparam int FSRU_B1_PROT = 2;
  localparam int FSRU_B1_LATCH = 1;
  localparam int FSRU_B1_BUSY = 0;
  // Status byte two positions
  localparam int FSRU_B2_RESET_COMMAND_ENABLE = 4;
  localparam int FSRU_B2_BUSY = 0;
  // Write-status data byte positions
  localparam int FSRU_WSR_LOCK = 7;
  localparam int FSRU_WSR_PROT = 2;

  // Reset values
  localparam logic FSRU_RST_LOCK = 1'b0;
  localparam logic FSRU_RST_PROT = 1'b0;
  localparam logic FSRU_RST_LATCH = 1'b0;
  localparam logic FSRU_RST_ERR = 1'b0;
  localparam logic FSRU_RST_RESET_COMMAND_ENABLE = 1'b0;
  // Synchroniser reset image: {cs_n, sck, si, wp_n}
  localparam logic [3:0] FSRU_PIN_RST = 4'h9;

  typedef enum logic [1:0] {
    FSRU_ST_OPCODE = 2'b00,
    FSRU_ST_READ = 2'b01,
    FSRU_ST_WSR = 2'b10,
    FSRU_ST_SKIP = 2'b11
  } fsru_state_t;

  // Signals from the command engines
  typedef struct packed {
    logic busy;       // Internal operation in progress
    logic op_done;    // Program or erase finished (pulse)
    logic op_fail;    // Valid with op_done: a byte failed
    logic wel_set;    // Write enable command accepted (pulse)
    logic wel_clr;    // Op completed or aborted after full opcode (pulse)
    logic hold_abort; // Hold condition aborted (pulse)
    logic reset_op;   // Reset command received (pulse)
    logic reset_command_enable_wr;    // Byte-two write accepted (pulse)
    logic reset_command_enable_val;   // Value for reset command enable
  } fsru_engine_in_t;

  // Status seen by the engines
  typedef struct packed {
    logic protection_lock;
    logic program_error_flag;
    logic protect_pin_mirror;
    logic array_protect;
    logic write_latch;
    logic busy_flag;
    logic reset_command_enable;
  } fsru_status_t;

  // Builds both status bytes, byte one in the upper half
  function automatic logic [15:0] fsru_pack_status(input fsru_status_t s);
    logic [7:0] b1;
    logic [7:0] b2;
    b1 = 8'h00;
    b2 = 8'h00;
    b1[FSRU_B1_LOCK] = s.protection_lock;
    b1[FSRU_B1_ERR] = s.program_error_flag;
    b1[FSRU_B1_MIRROR] = s.protect_pin_mirror;
    b1[FSRU_B1_PROT] = s.array_protect;
    b1[FSRU_B1_LATCH] = s.write_latch;
    b1[FSRU_B1_BUSY] = s.busy_flag;
    b2[FSRU_B2_RESET_COMMAND_ENABLE] = s.reset_command_enable;
    b2[FSRU_B2_BUSY] = s.busy_flag;
    return {b1, b2};
  endfunction : fsru_pack_status

endpackage : fsru_pkg

/* verilog/fsru_sync.sv */
/*
  Two-flop synchroniser bank for the serial pins.
  Assumes inputs are asynchronous to mclk_i; only stage two is read.
*/
`timescale 1ns/1ps
module fsru_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;

  // Metastability stages, reset to idle pin levels
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= RESET_VAL;
      sync_o <= RESET_VAL;
    end else begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end

endmodule : fsru_sync

/* verilog/fsru_wsr_check.sv */
/*
  Decision logic for a write-status command: given the current lock and
  protect bits, the protect pin and the received byte, yields the next
  values and whether the command takes effect.
  Assumes the caller has already checked latch and byte framing.
*/
`timescale 1ns/1ps
module fsru_wsr_check
  import fsru_pkg::*;
(
  input wire logic lock_i,
  input wire logic prot_i,
  input wire logic wp_asserted_i,
  input wire logic [7:0] data_i,
  output logic accept_o,
  output logic lock_next_o,
  output logic prot_next_o
);

  logic want_lock;
  logic want_prot;

  // Lock may only rise while the pin is asserted; a clear attempt drops all
  always_comb begin
    want_lock = data_i[FSRU_WSR_LOCK];
    want_prot = data_i[FSRU_WSR_PROT];
    accept_o = !(wp_asserted_i && lock_i && !want_lock); // R10
    lock_next_o = accept_o ? want_lock : lock_i;
    // Prior lock and pin decide, so a same-command lock cannot freeze protect
    if (accept_o && !(lock_i && wp_asserted_i)) begin // R8 R9
      prot_next_o = want_prot;
    end else begin
      prot_next_o = prot_i;
    end
  end

endmodule : fsru_wsr_check

/* testbench/fsru_spi_host.sv */
/*
  Host SPI controller model in mode 0: drives chip select, serial clock
  and serial data, and captures serial output bits on rising edges.
  Assumes a free-running mclk_i, used to time the serial clock and to toggle the idle data line.
*/
`timescale 1ns/1ps
module fsru_spi_host (
  input wire logic mclk_i,
  input wire logic so_i,
  input wire logic so_oe_i,
  output logic cs_n_o,
  output logic sck_o,
  output logic si_o
);
  // Half serial period in mclk cycles, well above the three-cycle minimum
  localparam int HALF = 8;
  logic in_frame = 1'b0;

  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
  end

  // Released data line toggles, so a stale value is never mistaken for data
  always @(posedge mclk_i) begin
    if (!in_frame) si_o <= ~si_o;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : wait_clk

  // Sends nb bits of v MSB first; bits after the opcode are captured in rx
  task automatic xfer(input logic [39:0] v, input int nb, output logic [31:0] rx, output logic oe);
    rx = 32'h0000_0000;
    oe = 1'b0;
    in_frame = 1'b1;
    cs_n_o = 1'b0;
    wait_clk(3);
    for (int i = 0; i < nb; i++) begin
      si_o = v[39-i];
      wait_clk(HALF);
      if (i >= 8) rx[39-i] = so_i;
      oe = so_oe_i;
      sck_o = 1'b1;
      wait_clk(HALF);
      sck_o = 1'b0;
    end
    wait_clk(HALF);
    cs_n_o = 1'b1;
    in_frame = 1'b0;
    wait_clk(4);
  endtask : xfer
endmodule : fsru_spi_host

/* testbench/fsru_status_unit_test.sv */
/*
  Self-checking bench of the flash status register unit: status reads,
  write-status rules, protect-pin locking and engine pulses.
  Assumes the host model file is compiled before this one.
*/
`timescale 1ns/1ps
module fsru_status_unit_test;
  import fsru_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wp_n_i = 1'b1;
  fsru_engine_in_t eng_i = '0;
  logic cs_n, sck, si, so, so_oe, reset_taken, oe;
  fsru_status_t status;
  logic [31:0] rx;
  int n_mismatch = 0;
  int n_checks = 0;

  // 20 MHz system clock
  always #25 mclk_i = ~mclk_i;

  fsru_status_unit fsru_status_unit_inst (.mclk_i(mclk_i), .rst_i(rst_i), .cs_n_i(cs_n), .sck_i(sck),
    .si_i(si), .wp_n_i(wp_n_i), .eng_i(eng_i), .so_o(so), .so_oe_o(so_oe), .status_o(status),
    .reset_taken_o(reset_taken));
  fsru_spi_host fsru_spi_host_inst (.mclk_i(mclk_i), .so_i(so), .so_oe_i(so_oe), .cs_n_o(cs_n),
    .sck_o(sck), .si_o(si));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  task automatic clk(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : clk

  // Expected status, busy taken from what the bench drives
  function automatic fsru_status_t st(input logic l, e, m, p, w, r);
    return '{l, e, m, p, w, eng_i.busy, r};
  endfunction : st

  // One-cycle engine pulse; busy level is kept
  task automatic pulse(input fsru_engine_in_t e);
    e.busy = eng_i.busy;
    eng_i = e;
    clk(1);
    eng_i = '{busy: e.busy, default: 1'b0};
  endtask : pulse

  task automatic set_latch;
    pulse('{wel_set: 1'b1, default: 1'b0});
  endtask : set_latch

  // Write-status frame of nb bits, then time for the update to land
  task automatic wsr(input logic [7:0] d, input int nb);
    fsru_spi_host_inst.xfer({8'h01, d, 24'h00_0000}, nb, rx, oe);
    clk(2);
  endtask : wsr

  task automatic t_reset;
    check(status, st(0, 0, 1, 0, 0, 0), "reset status");
    check(so_oe, 1'b0, "reset oe");
  endtask : t_reset

  // Read while busy; busy drops mid first pass, second pass must see it
  task automatic t_read;
    eng_i.busy = 1'b1;
    fork
      fsru_spi_host_inst.xfer({8'h05, 32'h0000_0000}, 40, rx, oe);
      begin
        clk(195);
        eng_i.busy = 1'b0;
      end
    join
    check(oe, 1'b1, "read oe");
    check(rx[31:24], 8'h11, "byte one busy");
    check(rx[23:16], 8'h01, "byte two busy copy");
    check(rx[15:0], 16'h1000, "second pass");
    check(so_oe, 1'b0, "oe after read");
    fsru_spi_host_inst.xfer({8'h05, 32'h0000_0000}, 11, rx, oe);
    check({oe, so_oe, rx[31:29]}, 5'h10, "mid byte release");
  endtask : t_read

  task automatic t_write;
    set_latch();
    check(status, st(0, 0, 1, 0, 1, 0), "latch set");
    wsr(8'hFF, 16);
    check(status, st(1, 0, 1, 1, 0, 0), "write all ones");
    fsru_spi_host_inst.xfer({8'h05, 32'h0000_0000}, 24, rx, oe);
    check(rx[31:16], 16'h9400, "read back");
  endtask : t_write

  // Pin asserted with lock set: protect frozen, lock cannot fall
  task automatic t_lock;
    wp_n_i = 1'b0;
    clk(4);
    check(status, st(1, 0, 0, 1, 0, 0), "mirror low");
    set_latch();
    wsr(8'h80, 16);
    check(status, st(1, 0, 0, 1, 0, 0), "protect frozen");
    set_latch();
    wsr(8'h04, 16);
    check(status, st(1, 0, 0, 1, 0, 0), "lock kept");
    wp_n_i = 1'b1;
    clk(4);
    set_latch();
    wsr(8'h00, 16);
    check(status, st(0, 0, 1, 0, 0, 0), "lock cleared");
    wp_n_i = 1'b0;
    clk(4);
    set_latch();
    wsr(8'h04, 16);
    check(status, st(0, 0, 0, 1, 0, 0), "unlocked protect");
    set_latch();
    wsr(8'h80, 16);
    check(status, st(1, 0, 0, 0, 0, 0), "lock rises");
    wp_n_i = 1'b1;
    clk(4);
    set_latch();
    wsr(8'h00, 16);
    check(status, st(0, 0, 1, 0, 0, 0), "lock cleared again");
  endtask : t_lock

  // Refused and cut-short frames
  task automatic t_refuse;
    wsr(8'h84, 16);
    check(status, st(0, 0, 1, 0, 0, 0), "latch clear refuses");
    set_latch();
    wsr(8'h84, 13);
    check(status, st(0, 0, 1, 0, 0, 0), "truncated write");
    set_latch();
    fsru_spi_host_inst.xfer(40'h00_0000_0000, 4, rx, oe);
    clk(2);
    check(status.write_latch, 1'b1, "partial opcode");
    fsru_spi_host_inst.xfer({8'hAB, 32'h0000_0000}, 16, rx, oe);
    clk(2);
    check(status.write_latch, 1'b1, "unknown opcode");
  endtask : t_refuse

  task automatic t_engine;
    pulse('{op_done: 1'b1, op_fail: 1'b1, default: 1'b0});
    check(status, st(0, 1, 1, 0, 1, 0), "error set");
    pulse('{hold_abort: 1'b1, default: 1'b0});
    check(status, st(0, 1, 1, 0, 0, 0), "hold abort");
    set_latch();
    pulse('{wel_clr: 1'b1, default: 1'b0});
    check(status, st(0, 1, 1, 0, 0, 0), "latch cleared");
    pulse('{op_done: 1'b1, default: 1'b0});
    check(status.program_error_flag, 1'b0, "error refreshed");
    pulse('{wel_set: 1'b1, wel_clr: 1'b1, default: 1'b0});
    check(status.write_latch, 1'b1, "set wins");
    pulse('{reset_command_enable_wr: 1'b1, reset_command_enable_val: 1'b1, default: 1'b0});
    eng_i.reset_op = 1'b1;
    #1;
    check(reset_taken, 1'b1, "reset taken");
    clk(1);
    eng_i.reset_op = 1'b0;
    check(status, st(0, 0, 1, 0, 0, 1), "after reset op");
    fsru_spi_host_inst.xfer({8'h05, 32'h0000_0000}, 24, rx, oe);
    check(rx[31:16], 16'h1010, "byte two enable");
  endtask : t_engine

  // Watchdog: whole sequence needs about 4450 cycles
  initial begin
    clk(40000);
    n_mismatch++;
    give_verdict();
  end

  initial begin
    repeat (3) @(posedge mclk_i);
    #1;
    rst_i = 1'b0;
    clk(4);
    t_reset();
    t_read();
    t_write();
    t_lock();
    t_refuse();
    t_engine();
    give_verdict();
  end
endmodule : fsru_status_unit_test
